/* File: hdl/aop_defines.vh */
// Constants for the converter output and power-down block
`ifndef AOP_DEFINES_VH
`define AOP_DEFINES_VH

// Data path widths
`define AOP_CODE_W 14
`define AOP_CODE_MSB 13
`define AOP_SYNC_W 20
`define AOP_PTR_W 5
`define AOP_DEPTH 32
`define AOP_WORD_W 16

// Whole sampling cycles of latency; the extra half cycle comes from the edge pair
`define AOP_LAT_FULL_CYC 5'h10

// Overdrive clamp codes in each coding
`define AOP_FS_POS_OB 14'h0fff
`define AOP_FS_POS_TC 14'h07ff
`define AOP_FS_NEG_OB 14'h0000
`define AOP_FS_NEG_TC 14'h0800

// Full-scale limits of the raw offset-binary core code
`define AOP_RAW_MIN 14'h0000
`define AOP_RAW_MAX 14'h3fff

// Slow-clock power-down detection
`define AOP_REF_PERIOD_NS 8
`define AOP_SLOW_PERIOD_NS 1000
`define AOP_SLOW_CYC_INT ((`AOP_SLOW_PERIOD_NS + `AOP_REF_PERIOD_NS - 1) / `AOP_REF_PERIOD_NS)
`define AOP_CNT_W 8

// Default level-to-mode map: two bits per level, {edge_fall, coding_tc}
`define AOP_FMT_MAP_DEF 8'he4

// Register byte offsets
`define AOP_ADDR_W 8
`define AOP_REG_CTRL 8'h00
`define AOP_REG_STATUS 8'h04
`define AOP_REG_INT_STAT 8'h08
`define AOP_REG_INT_MASK 8'h0c
`define AOP_REG_DATA 8'h10

// Field positions
`define AOP_CTRL_PD 0
`define AOP_INT_W 3
`define AOP_INT_OVR 0
`define AOP_INT_PD_ENTER 1
`define AOP_INT_PD_EXIT 2

`endif

/* File: hdl/aop_sync.v */
// Two-flop synchroniser for inputs from outside the reference clock domain
`timescale 1ns/100ps
`default_nettype none

module aop_sync #(
    parameter W = 1
) (
    // Clock and reset
    input wire ref_clk,
    input wire rst,
    // Asynchronous input and synchronised output
    input wire [W-1:0] async_in,
    output wire [W-1:0] sync_out
);

    reg [W-1:0] meta_ff;
    reg [W-1:0] sync_ff;

    // First stage feeds only the second stage
    always @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            meta_ff <= {W{1'b0}};
            sync_ff <= {W{1'b0}};
        end
        else
        begin
            meta_ff <= async_in;
            sync_ff <= meta_ff;
        end
    end

    assign sync_out = sync_ff;

endmodule // aop_sync

`default_nettype wire

/* File: hdl/aop_top.v */
// Converter output word, format select, overdrive clamp and power-down control
//
// Local design decisions: the address map and the APB register port.
`timescale 1ns/100ps
`default_nettype none
`include "aop_defines.vh"

module aop_top #(
    parameter [7:0] FMT_MAP = `AOP_FMT_MAP_DEF
) (
    // Clock and reset
    input wire ref_clk,
    input wire rst,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [`AOP_ADDR_W-1:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output reg pslverr,
    // Interrupt
    output wire irq,
    // Sampling clock from the far side
    input wire samp_clk,
    // Conversion core result
    input wire [`AOP_CODE_MSB:0] conv_code,
    input wire over_pos,
    input wire over_neg,
    // Control pins
    input wire [1:0] format_select_pin,
    input wire out_en_pin,
    // Output pins
    output wire [`AOP_CODE_MSB:0] data_out,
    output wire data_oe,
    output wire data_ready_clock,
    output wire data_ready_clock_oe,
    output wire out_of_range_flag,
    output wire out_of_range_flag_oe
);

    // Trip count worked out in 32 bits, then cut to the counter width on purpose
    localparam [31:0] SLOW_CYC_I = `AOP_SLOW_CYC_INT;
    localparam [`AOP_CNT_W-1:0] SLOW_CYC = SLOW_CYC_I[`AOP_CNT_W-1:0];

    // Synchronised pins
    wire [`AOP_SYNC_W-1:0] sync_bus;
    wire s_clk;
    wire [`AOP_CODE_MSB:0] s_code;
    wire s_pos;
    wire s_neg;
    wire [1:0] s_fmt;
    wire s_oe;

    reg clk_d_ff;
    wire clk_rise;
    wire clk_fall;
    reg [`AOP_WORD_W-1:0] mem_ff [0:`AOP_DEPTH-1];
    reg [`AOP_PTR_W-1:0] wr_ptr_ff;
    wire [`AOP_PTR_W-1:0] nxt_wr_ptr;
    wire [`AOP_PTR_W-1:0] rd_idx;
    wire [`AOP_WORD_W-1:0] rd_word;
    reg [`AOP_CODE_MSB:0] data_ff;
    reg ovr_ff;
    reg drc_ff;
    reg [`AOP_CNT_W-1:0] per_cnt_ff;
    reg clk_pd_ff;
    reg pd_ctrl_ff;
    reg [`AOP_INT_W-1:0] int_stat_ff;
    reg [`AOP_INT_W-1:0] int_mask_ff;
    reg [`AOP_INT_W-1:0] nxt_int_event;
    reg coding_tc;
    reg edge_fall;
    reg [`AOP_CODE_MSB:0] nxt_data;
    reg nxt_ovr;
    wire [1:0] map_bits;
    wire [7:0] map_shift;
    wire run;
    wire wr_en;
    wire rd_en;
    integer i;

    // Word bits cross one by one; this is safe only because the far side holds
    // the code steady for the whole low phase in which the fall takes it
    aop_sync #(
        .W(`AOP_SYNC_W)
    ) u_sync (
        .ref_clk(ref_clk),
        .rst(rst),
        .async_in({out_en_pin, format_select_pin, over_neg, over_pos, conv_code, samp_clk}),
        .sync_out(sync_bus)
    );

    assign s_clk = sync_bus[0];
    assign s_code = sync_bus[`AOP_CODE_W:1];
    assign s_pos = sync_bus[`AOP_CODE_W+1];
    assign s_neg = sync_bus[`AOP_CODE_W+2];
    assign s_fmt = sync_bus[`AOP_CODE_W+4:`AOP_CODE_W+3];
    assign s_oe = sync_bus[`AOP_CODE_W+5];

    // Sampling clock edges found on the reference clock; both are used
    always @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            clk_d_ff <= 1'b0;
        else
            clk_d_ff <= s_clk;
    end

    assign clk_rise = s_clk & ~clk_d_ff;
    assign clk_fall = ~s_clk & clk_d_ff;

    // Level map picks the mode pair; kept as a parameter so boards can differ.
    // The selected pair is shifted to the bottom and the upper bits are dropped.
    assign map_shift = FMT_MAP >> {s_fmt, 1'b0};
    assign map_bits = map_shift[1:0];

    always @*
    begin
        coding_tc = map_bits[0];
        edge_fall = map_bits[1];
    end

    // Slow clock detector: period in reference cycles, saturating for DC.
    // The trip sits at 1 us; exact value is unimportant since any rate
    // under 10 MHz may power down, so hysteresis is one full fast period.
    always @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            per_cnt_ff <= {`AOP_CNT_W{1'b0}};
            clk_pd_ff <= 1'b0;
        end
        else
        begin
            if (clk_rise)
                per_cnt_ff <= {`AOP_CNT_W{1'b0}};
            else if (per_cnt_ff != SLOW_CYC)
                per_cnt_ff <= per_cnt_ff + 1'b1;
            if (per_cnt_ff == SLOW_CYC)
                clk_pd_ff <= 1'b1;
            else if (clk_rise)
                clk_pd_ff <= 1'b0;
        end
    end

    // Register power-down and slow-clock power-down both freeze the path
    assign run = ~pd_ctrl_ff & ~clk_pd_ff;
    assign wr_en = clk_fall & run;
    assign rd_en = clk_rise & run;

    // Sample capture on the falling edge into a flop ring
    assign nxt_wr_ptr = wr_ptr_ff + 1'b1;

    always @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            wr_ptr_ff <= {`AOP_PTR_W{1'b0}};
            for (i = 0; i < `AOP_DEPTH; i = i + 1)
                mem_ff[i] <= {`AOP_WORD_W{1'b0}};
        end
        else if (wr_en)
        begin
            wr_ptr_ff <= nxt_wr_ptr;
            mem_ff[nxt_wr_ptr] <= {s_neg, s_pos, s_code};
        end
    end

    // The ring is twice the look-back, so a write never lands on the slot being read
    // Sample taken 16 falls back leaves on the next rise: 16.5 cycles
    assign rd_idx = wr_ptr_ff - `AOP_LAT_FULL_CYC;
    assign rd_word = mem_ff[rd_idx];

    // Coding, overdrive clamp and limit flag for the outgoing word
    always @*
    begin
        nxt_ovr = rd_word[`AOP_CODE_W] | rd_word[`AOP_CODE_W+1] |
            (rd_word[`AOP_CODE_MSB:0] == `AOP_RAW_MIN) |
            (rd_word[`AOP_CODE_MSB:0] == `AOP_RAW_MAX);
        if (rd_word[`AOP_CODE_W])
            nxt_data = coding_tc ? `AOP_FS_POS_TC : `AOP_FS_POS_OB;
        else if (rd_word[`AOP_CODE_W+1])
            nxt_data = coding_tc ? `AOP_FS_NEG_TC : `AOP_FS_NEG_OB;
        else if (coding_tc)
            nxt_data = {~rd_word[`AOP_CODE_MSB], rd_word[`AOP_CODE_MSB-1:0]};
        else
            nxt_data = rd_word[`AOP_CODE_MSB:0];
    end

    // Word and flag update together on the rise; the flag never lags its word
    always @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            data_ff <= {`AOP_CODE_W{1'b0}};
            ovr_ff <= 1'b0;
        end
        else if (rd_en)
        begin
            data_ff <= nxt_data;
            ovr_ff <= nxt_ovr;
        end
    end

    // Data-ready clock: its latch edge lands mid-way between word changes
    always @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            drc_ff <= 1'b0;
        else
            drc_ff <= edge_fall ? s_clk : ~s_clk;
    end

    // Reset drives outputs low; otherwise enable pin and register power-down gate them
    // Slow-clock power-down keeps the pins driven with the last word frozen
    assign data_out = data_ff;
    assign data_ready_clock = drc_ff;
    assign out_of_range_flag = ovr_ff;
    assign data_oe = rst | (s_oe & ~pd_ctrl_ff);
    assign data_ready_clock_oe = data_oe;
    assign out_of_range_flag_oe = data_oe;

    // Interrupt events: flagged word leaves, slow-clock power-down in and out
    always @*
    begin
        nxt_int_event = {`AOP_INT_W{1'b0}};
        nxt_int_event[`AOP_INT_OVR] = rd_en & nxt_ovr;
        nxt_int_event[`AOP_INT_PD_ENTER] = (per_cnt_ff == SLOW_CYC) & ~clk_pd_ff;
        nxt_int_event[`AOP_INT_PD_EXIT] = clk_pd_ff & clk_rise & (per_cnt_ff != SLOW_CYC);
    end

    // APB write side; a new event beats a write-one-to-clear in the same cycle
    always @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            pd_ctrl_ff <= 1'b0;
            int_mask_ff <= {`AOP_INT_W{1'b0}};
            int_stat_ff <= {`AOP_INT_W{1'b0}};
        end
        else
        begin
            if (psel & penable & pwrite)
            begin
                if (paddr == `AOP_REG_CTRL)
                    pd_ctrl_ff <= pwdata[`AOP_CTRL_PD];
                else if (paddr == `AOP_REG_INT_MASK)
                    int_mask_ff <= pwdata[`AOP_INT_W-1:0];
            end
            if (psel & penable & pwrite & (paddr == `AOP_REG_INT_STAT))
                int_stat_ff <= (int_stat_ff & ~pwdata[`AOP_INT_W-1:0]) | nxt_int_event;
            else
                int_stat_ff <= int_stat_ff | nxt_int_event;
        end
    end

    // Level output; stays up until software clears or masks every cause
    assign irq = |(int_stat_ff & int_mask_ff);

    // Zero-wait slave; unmapped addresses answer with an error and zero data
    assign pready = 1'b1;

    always @*
    begin
        prdata = 32'h0000_0000;
        pslverr = 1'b0;
        if (psel & penable)
        begin
            if (paddr == `AOP_REG_CTRL)
                prdata = {31'h0000_0000, pd_ctrl_ff};
            else if (paddr == `AOP_REG_STATUS)
                prdata = {27'h000_0000, s_oe, edge_fall, coding_tc, pd_ctrl_ff, clk_pd_ff};
            else if (paddr == `AOP_REG_INT_STAT)
                prdata = {29'h0000_0000, int_stat_ff};
            else if (paddr == `AOP_REG_INT_MASK)
                prdata = {29'h0000_0000, int_mask_ff};
            else if (paddr == `AOP_REG_DATA)
                prdata = {17'h0_0000, ovr_ff, data_ff};
            else
                pslverr = 1'b1;
        end
    end

endmodule // aop_top

`default_nettype wire

/* File: verif/aop_top_props.sv */
// Property checker for the converter output block
`timescale 1ns/100ps
`default_nettype none
module aop_top_chk (
    // Clock, reset and bus
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic irq,
    // Sample side and pins
    input wire logic over_pos,
    input wire logic out_en_pin,
    input wire logic [13:0] data_out,
    input wire logic data_oe,
    input wire logic data_ready_clock,
    input wire logic data_ready_clock_oe,
    input wire logic out_of_range_flag,
    input wire logic out_of_range_flag_oe
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    logic [9:0] pos_ff;
    // Overdrive run length; saturates so a long hold never wraps
    always_ff @(posedge ref_clk or posedge rst)
        if (rst)
            pos_ff <= 10'h0;
        else if (!over_pos)
            pos_ff <= 10'h0;
        else if (pos_ff != 10'h3ff)
            pos_ff <= pos_ff + 10'h1;
    sequence s_pd_set;
        psel && penable && pwrite && paddr == 8'h00 && pwdata[0];
    endsequence
    chk_reset_low: assert property ($fell(rst) |-> data_out == 14'h0 && !out_of_range_flag && !irq)
        else $error("outputs not low after reset");
    chk_pd_tristate: assert property (s_pd_set |=> !data_oe && !out_of_range_flag_oe)
        else $error("outputs driven in power-down");
    chk_oe_pin: assert property (!out_en_pin [*3] |-> !data_oe && !data_ready_clock_oe)
        else $error("outputs driven with enable low");
    chk_word_edge: assert property ($changed(data_out) |-> $changed(data_ready_clock))
        else $error("word moved without ready clock");
    chk_flag_edge: assert property ($changed(out_of_range_flag) |-> $changed(data_ready_clock))
        else $error("flag moved without ready clock");
    chk_clamp_pos: assert property (pos_ff == 10'h190 |->
        out_of_range_flag && (data_out == 14'h0fff || data_out == 14'h07ff))
        else $error("positive overdrive not clamped");
    chk_ready_now: assert property (psel |-> pready)
        else $error("wait state inserted");
    chk_err_map: assert property (psel && penable && paddr[1:0] == 2'h0 |-> pslverr == (paddr > 8'h10))
        else $error("error response wrong");
    chk_irq_mask: assert property (psel && penable && pwrite && paddr == 8'h0c && pwdata[2:0] == 3'h0
        |=> !irq)
        else $error("masked interrupt raised");
endmodule // aop_top_chk
bind aop_top aop_top_chk u_chk (
    .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .over_pos(over_pos), .out_en_pin(out_en_pin), .data_out(data_out), .data_oe(data_oe),
    .data_ready_clock(data_ready_clock), .data_ready_clock_oe(data_ready_clock_oe),
    .out_of_range_flag(out_of_range_flag), .out_of_range_flag_oe(out_of_range_flag_oe)
);
`default_nettype wire

/* File: verif/aop_far_model.sv */
// Capture-side partner: sampling clock and core result source
`timescale 1ns/100ps
`default_nettype none
module aop_far_model (
    // From the bench
    input wire logic run,
    input wire logic [13:0] code_in,
    input wire logic pos_in,
    input wire logic neg_in,
    // Into the block
    output logic samp_clk,
    output logic [13:0] conv_code,
    output logic over_pos,
    output logic over_neg
);
    // Even duty because both edges move samples; clock stands low when stopped
    initial
    begin
        samp_clk = 1'b0;
        conv_code = 14'h0;
        over_pos = 1'b0;
        over_neg = 1'b0;
        forever
        begin
            wait (run);
            #62.5 samp_clk = 1'b1;
            conv_code = code_in; // Moves at the rise, steady over the capturing fall
            over_pos = pos_in;
            over_neg = neg_in;
            #62.5 samp_clk = 1'b0;
        end
    end
endmodule // aop_far_model
`default_nettype wire

/* File: verif/aop_top_bench.sv */
// Self-checking bench for the converter output block
`timescale 1ns/100ps
`default_nettype none
module aop_top_bench;
    logic ref_clk, rst, psel, penable, pwrite, pready, pslverr, irq, samp_clk, over_pos, over_neg;
    logic out_en_pin, data_oe, data_ready_clock, data_ready_clock_oe;
    logic out_of_range_flag, out_of_range_flag_oe, run, pos, neg;
    logic [1:0] format_select_pin;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, seed, exp_v;
    logic [13:0] conv_code, data_out, code;
    logic [31:0] notes[$];
    int bad_count, checks_done, cyc;
    aop_top dut (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .irq(irq), .samp_clk(samp_clk), .conv_code(conv_code), .over_pos(over_pos),
        .over_neg(over_neg), .format_select_pin(format_select_pin), .out_en_pin(out_en_pin),
        .data_out(data_out), .data_oe(data_oe), .data_ready_clock(data_ready_clock),
        .data_ready_clock_oe(data_ready_clock_oe), .out_of_range_flag(out_of_range_flag),
        .out_of_range_flag_oe(out_of_range_flag_oe));
    aop_far_model far (.run(run), .code_in(code), .pos_in(pos), .neg_in(neg),
        .samp_clk(samp_clk), .conv_code(conv_code), .over_pos(over_pos), .over_neg(over_neg));
    initial
    begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    task report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Hang guard, well above the planned run length
    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == 30000)
        begin
            bad_count++;
            report_and_stop();
        end
    end
    // Each completed read retires the oldest note
    always @(posedge ref_clk)
        if (psel && penable && pready && !pwrite)
        begin
            exp_v = notes.pop_front();
            chk("prdata", prdata, exp_v);
            if (paddr == 8'h10 && data_oe)
                chk("pins", {17'h0, out_of_range_flag, data_out}, exp_v);
        end
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (!pready)
            @(posedge ref_clk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e);
        notes.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask
    function logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    // Default map: level bit 0 picks two's complement
    function logic [31:0] word(input logic t, input logic [13:0] r, input logic p, input logic n);
        if (p)
            return {17'h0, 1'b1, t ? 14'h07ff : 14'h0fff};
        if (n)
            return {17'h0, 1'b1, t ? 14'h0800 : 14'h0000};
        return {17'h0, r == 14'h0 || r == 14'h3fff, r ^ {t, 13'h0}};
    endfunction
    initial
    begin
        {rst, out_en_pin, seed} = {2'h3, 32'h6db211f0};
        {psel, penable, pwrite, paddr, pwdata, format_select_pin} = 45'h0;
        {run, pos, neg, code} = 17'h0;
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        rd(8'h00, 32'h0);
        rd(8'h10, 32'h0);
        rd(8'h20, 32'h0);
        apb(1'b1, 8'h00, 32'h1);
        rd(8'h00, 32'h1);
        apb(1'b1, 8'h00, 32'h0);
        $display("done registers");
        for (int lv = 0; lv < 4; lv++)
        begin
            // Clock stood still while the format moves, so no word shifts as the
            // output clock swaps polarity
            run <= 1'b0;
            repeat (20) @(posedge ref_clk);
            format_select_pin <= lv[1:0];
            repeat (4) @(posedge ref_clk);
            run <= 1'b1;
            for (int k = 0; k < 4; k++)
            begin
                seed = xs(seed);
                code <= k == 1 ? 14'h3fff : seed[13:0];
                pos <= k == 2;
                neg <= k == 3;
                repeat (500) @(posedge ref_clk);
                rd(8'h10, word(lv[0], k == 1 ? 14'h3fff : seed[13:0], k == 2, k == 3));
            end
            rd(8'h04, {27'h0, 1'b1, lv[1:0], 2'h0});
        end
        $display("done formats");
        {code, pos, neg} <= {14'h1234, 2'h0};
        repeat (500) @(posedge ref_clk);
        apb(1'b1, 8'h0c, 32'h7);
        // Mask lands at the write's edge; look one edge later
        @(posedge ref_clk);
        chk("irq", {31'h0, irq}, 32'h1);
        apb(1'b1, 8'h08, 32'h7);
        rd(8'h08, 32'h0);
        run <= 1'b0;
        repeat (400) @(posedge ref_clk);
        rd(8'h04, 32'h1d);
        chk("irq", {31'h0, irq}, 32'h1);
        run <= 1'b1;
        repeat (100) @(posedge ref_clk);
        rd(8'h08, 32'h6);
        apb(1'b1, 8'h0c, 32'h0);
        $display("done interrupts");
        apb(1'b1, 8'h00, 32'h1);
        code <= 14'h0abc;
        repeat (500) @(posedge ref_clk);
        rd(8'h10, 32'h3234);
        rd(8'h04, 32'h1e);
        apb(1'b1, 8'h00, 32'h0);
        out_en_pin <= 1'b0;
        repeat (5) @(posedge ref_clk);
        rd(8'h04, 32'h0c);
        out_en_pin <= 1'b1;
        $display("done power-down");
        // Sampling clock parked low so no word moves across the release
        run <= 1'b0;
        repeat (20) @(posedge ref_clk);
        rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        rd(8'h0c, 32'h0);
        rd(8'h10, 32'h0);
        $display("done reset");
        report_and_stop();
    end
endmodule // aop_top_bench
`default_nettype wire
